// *** src/sslt_timing.sv ***
/*
 Line timing for a linear image sensor and its lamps, with front end channel sequencing.
 Assumes a plain register port on CLK and a sensor driven straight from these pins.
*/
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module sslt_timing
    import sslt_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_B,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    output logic                   LAMP_R,
    output logic                   LAMP_G,
    output logic                   LAMP_B,
    output logic                   PHI1,
    output logic                   FIRST_TRANSFER_PULSE,
    output logic                   SECOND_TRANSFER_PULSE,
    output logic                   RESET_GATE_PULSE,
    output logic                   AUX_PULSE_A,
    output logic                   AUX_PULSE_B,
    output logic                   CLAMP,
    output logic                   SAMPLE_REF,
    output logic                   SAMPLE_SIG,
    output logic                   USE_INT_REF,
    output logic                   ADC_CONV,
    output logic      [1:0]        MUX_SEL,
    output logic                   SCAN_ACTIVE,
    output logic                   LINE_START
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NREG-1:0][DATA_W-1:0] regs;
        logic [DATA_W-1:0]           rdata;
        logic [15:0]                 pix;
        logic [2:0]                  sub;
        logic [1:0]                  colour;
        logic [1:0]                  chan;
        logic [2:0][1:0]             skipc;
        logic [2:0]                  lamp;
        logic                        scan;
        logic                        lstart;
        logic                        intref;
        sslt_sens_t                  o;
    } sslt_st_t;

    sslt_st_t r, s;

    logic        pwm_q;
    logic [15:0] ctrl;
    logic [15:0] line_end;
    logic        halt;
    logic        wrap;
    logic        phi_hi;
    logic        tr_base;
    logic        trw;
    logic        guard_on;
    logic [1:0]  lmode;
    logic [1:0]  afe;

    assign ctrl     = r.regs[REG_CTRL];
    assign line_end = r.regs[REG_LINEEND];
    assign lmode    = ctrl[CTL_LMODE+:2];
    assign afe      = ctrl[CTL_AFE+:2];
    assign halt     = ctrl[CTL_SRST] | ctrl[CTL_STBY];

    // ****************************************
    // Lamp dimming modulator
    // ****************************************
    sslt_pwm #(
        .W (PWM_W)
    ) u_pwm (
        .clk     (CLK),
        .rst_b   (RST_B),
        .run     (!halt),
        .duty    (r.regs[REG_PWM][PWM_W-1:0]),
        .pwm_out (pwm_q)
    );

    // Pulse window within one pixel, start and end in the low two nibbles
    function automatic logic in_win(input logic [2:0] sub, input logic [15:0] cfg);
        in_win = (sub >= cfg[2:0]) && (sub < cfg[6:4]);
    endfunction : in_win

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s = r;
        s.rdata  = '0;
        s.lstart = 1'b0;
        // Register port; status and pixel words are read only
        if (WR && (ADDR < NREG) && (ADDR != REG_STATUS) && (ADDR != REG_PIXEL))
        begin
            s.regs[ADDR] = WDATA;
        end
        if (RD)
        begin
            if (ADDR == REG_STATUS)
                s.rdata = {8'h00, r.chan, r.colour, r.lamp, r.scan};
            else if (ADDR == REG_PIXEL)
                s.rdata = r.pix;
            else if (ADDR < NREG)
                s.rdata = r.regs[ADDR];
        end

        wrap     = (r.sub == SUB_LAST) && (r.pix >= line_end);
        phi_hi   = r.sub < PHI_HALF;
        trw      = r.pix < r.regs[REG_TRW];
        guard_on = r.pix < (r.regs[REG_TRW] + r.regs[REG_GUARD]);
        tr_base  = 1'b0;

        if (halt)
        begin
            // Clocking stops; counters restart cleanly on release
            s.pix    = '0;
            s.sub    = '0;
            s.colour = COL_RED;
            s.chan   = '0;
            s.skipc  = '0;
            s.lamp   = '0;
            s.scan   = 1'b0;
            s.o      = '0;
        end
        else
        begin
            // Free-running pixel counter, also during idle and feed
            s.sub = 3'(r.sub + 1'b1);
            if (r.sub == SUB_LAST)
            begin
                s.pix = wrap ? 16'h0000 : 16'(r.pix + 1'b1);
            end
            if (wrap)
            begin
                s.lstart = 1'b1;
                s.colour = (r.colour == COL_BLUE) ? COL_RED : 2'(r.colour + 1'b1);
                // Scan begins only on a line boundary, red line in mode 2
                if (!ctrl[CTL_SCAN])
                    s.scan = 1'b0;
                else if ((lmode != LMODE_2) || (r.colour == COL_BLUE))
                    s.scan = 1'b1;
                for (int c = 0; c < 3; c++)
                begin
                    if (r.skipc[c] == 2'h0)
                        s.skipc[c] = r.regs[REG_SKIP][c*SKIP_STRIDE+:2];
                    else
                        s.skipc[c] = 2'(r.skipc[c] - 1'b1);
                end
            end

            // Lamps: on and off only ever match inside the line
            for (int c = 0; c < 3; c++)
            begin
                if ((r.sub == 3'h0) && (r.pix == r.regs[REG_LAMP0 + 2*c]))
                    s.lamp[c] = 1'b1;
                if ((r.sub == 3'h0) && (r.pix == r.regs[REG_LAMP0 + 2*c + 1]))
                    s.lamp[c] = 1'b0;
                if ((lmode == LMODE_2) && (2'(c) != r.colour))
                    s.lamp[c] = 1'b0;
            end

            // Transfer timing per mode
            case (ctrl[CTL_TRMODE+:2])
                TRM_CIS1: tr_base = (r.pix == 16'h0000);
                TRM_CIS2: tr_base = ((r.pix == 16'h0000) && (r.sub < CIS2_PRE)) ||
                                    ((r.pix >= line_end) && (r.sub >= CIS2_PRE));
                default:  tr_base = trw;
            endcase
            s.o.phi1 = phi_hi;
            if (ctrl[CTL_TRMODE+:2] == TRM_NORM)
            begin
                if (r.regs[REG_GUARD] == 16'h0000)
                begin
                    if (trw)
                        s.o.phi1 = 1'b1;
                end
                else if (guard_on)
                begin
                    s.o.phi1 = 1'b0;
                end
            end

            // Pixel rate pulses cleared in the last pixel of the line: reset gate unless fake black holds it, aux A always, aux B outside line rate mode
            s.o.rsg  = in_win(r.sub, r.regs[REG_RSG]) && (r.pix < line_end);
            s.o.auxa = in_win(r.sub, r.regs[REG_AUXA]) && (r.pix < line_end);
            s.o.auxb = in_win(r.sub, r.regs[REG_AUXB]) && (r.pix < line_end);
            s.o.clamp = r.pix < r.regs[REG_OBEND];
            s.o.tr1  = tr_base;
            s.o.tr2  = tr_base;
            if (ctrl[CTL_FAKEOB])
            begin
                // Single reset pulse in the first pixel, then held through black
                if (r.pix == 16'h0000)
                    s.o.tr1 = tr_base || (r.sub < r.regs[REG_RSG][6:4]);
                else
                    s.o.rsg = r.pix < r.regs[REG_OBEND];
            end

            // Separate colour transfers in line rate mode
            if (afe == AFE_LINE)
            begin
                s.o.tr1  = tr_base && (r.skipc[0] == 2'h0) &&
                           (r.regs[REG_SKIP][2] ? !phi_hi : phi_hi);
                s.o.tr2  = tr_base && (r.skipc[1] == 2'h0) &&
                           (r.regs[REG_SKIP][5] ? !phi_hi : phi_hi);
                s.o.auxb = tr_base && (r.skipc[2] == 2'h0) &&
                           (r.regs[REG_SKIP][8] ? !phi_hi : phi_hi);
            end

            // Sampling; spacing of the two points is software's duty
            s.o.sref  = ctrl[CTL_CDS] && (r.sub == r.regs[REG_SAMP][2:0]);
            s.o.ssig  = r.sub == r.regs[REG_SAMP][6:4];
            s.o.conv  = r.sub == r.regs[REG_SAMP][6:4];
            s.intref  = !ctrl[CTL_CDS];

            // Channel sequencing also picks the offset and gain set
            case (afe)
                AFE_PIX:
                begin
                    if (s.o.conv)
                        s.chan = (r.chan == COL_BLUE) ? COL_RED : 2'(r.chan + 1'b1);
                end
                AFE_LINE: s.chan = r.colour;
                AFE_GRAY: s.chan = ctrl[CTL_GRAYCH+:2];
                default:  s.chan = r.chan;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            r               <= '0;
            r.regs[REG_CTRL]    <= CTRL_RST;
            r.regs[REG_LINEEND] <= LINEEND_RST;
            r.regs[REG_TRW]     <= TRW_RST;
            r.regs[REG_RSG]     <= RSG_RST;
            r.regs[REG_SAMP]    <= SAMP_RST;
            r.regs[REG_OBEND]   <= OBEND_RST;
        end
        else
        begin
            r <= s;
        end
    end

    // Green follows the modulator in mode 1, one clock late to keep it registered
    logic lamp_g_q;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            lamp_g_q <= 1'b0;
        else
            lamp_g_q <= (lmode == LMODE_1) ? pwm_q : s.lamp[1];
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign RDATA                 = r.rdata;
    assign LAMP_R                = r.lamp[0];
    assign LAMP_G                = lamp_g_q;
    assign LAMP_B                = r.lamp[2];
    assign PHI1                  = r.o.phi1;
    assign FIRST_TRANSFER_PULSE  = r.o.tr1;
    assign SECOND_TRANSFER_PULSE = r.o.tr2;
    assign RESET_GATE_PULSE      = r.o.rsg;
    assign AUX_PULSE_A           = r.o.auxa;
    assign AUX_PULSE_B           = r.o.auxb;
    assign CLAMP                 = r.o.clamp;
    assign SAMPLE_REF            = r.o.sref;
    assign SAMPLE_SIG            = r.o.ssig;
    assign USE_INT_REF           = r.intref;
    assign ADC_CONV              = r.o.conv;
    assign MUX_SEL               = r.chan;
    assign SCAN_ACTIVE           = r.scan;
    assign LINE_START            = r.lstart;
endmodule : sslt_timing

// *** src/sslt_pkg.sv ***
/*
 Shared constants and carrier types for the scanner sensor and lamp timing block.
 Assumes one master clock; the pixel period is a fixed number of master clocks.
*/
package sslt_pkg;
    // ****************************************
    // Register map (word index on the plain port)
    // ****************************************
    localparam int          ADDR_W      = 5;
    localparam int          DATA_W      = 16;
    localparam int          NREG        = 19;
    localparam logic [4:0]  REG_CTRL    = 5'h00;
    localparam logic [4:0]  REG_LINEEND = 5'h01;
    localparam logic [4:0]  REG_LAMP0   = 5'h02;  // On/off pairs, red green blue
    localparam logic [4:0]  REG_PWM     = 5'h08;
    localparam logic [4:0]  REG_TRW     = 5'h09;
    localparam logic [4:0]  REG_GUARD   = 5'h0A;
    localparam logic [4:0]  REG_RSG     = 5'h0B;
    localparam logic [4:0]  REG_AUXA    = 5'h0C;
    localparam logic [4:0]  REG_AUXB    = 5'h0D;
    localparam logic [4:0]  REG_SAMP    = 5'h0E;
    localparam logic [4:0]  REG_OBEND   = 5'h0F;
    localparam logic [4:0]  REG_SKIP    = 5'h10;
    localparam logic [4:0]  REG_STATUS  = 5'h11;
    localparam logic [4:0]  REG_PIXEL   = 5'h12;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTL_LMODE   = 0;   // 2 bits: 1, 2 or 3
    localparam int CTL_AFE     = 2;   // 2 bits
    localparam int CTL_CDS     = 4;
    localparam int CTL_FAKEOB  = 5;
    localparam int CTL_TRMODE  = 6;   // 2 bits
    localparam int CTL_SRST    = 8;
    localparam int CTL_STBY    = 9;
    localparam int CTL_SCAN    = 10;
    localparam int CTL_GRAYCH  = 11;  // 2 bits
    localparam int SKIP_STRIDE = 3;   // Per colour: 2 bit skip, 1 bit position
    localparam logic [15:0] CTRL_RST    = 16'h0211;
    localparam logic [15:0] LINEEND_RST = 16'h00FF;
    localparam logic [15:0] TRW_RST     = 16'h0002;
    localparam logic [15:0] RSG_RST     = 16'h0064;
    localparam logic [15:0] SAMP_RST    = 16'h0062;
    localparam logic [15:0] OBEND_RST   = 16'h0010;
    // ****************************************
    // Modes and timing
    // ****************************************
    localparam logic [1:0] LMODE_1   = 2'h1;
    localparam logic [1:0] LMODE_2   = 2'h2;
    localparam logic [1:0] LMODE_3   = 2'h3;
    localparam logic [1:0] AFE_PIX   = 2'h0;
    localparam logic [1:0] AFE_LINE  = 2'h1;
    localparam logic [1:0] AFE_GRAY  = 2'h2;
    localparam logic [1:0] TRM_NORM  = 2'h0;
    localparam logic [1:0] TRM_CIS1  = 2'h1;
    localparam logic [1:0] TRM_CIS2  = 2'h2;
    localparam logic [1:0] COL_RED   = 2'h0;
    localparam logic [1:0] COL_BLUE  = 2'h2;
    localparam int         PIX_CLKS  = 8;     // Converter rate is master clock / 8
    localparam logic [2:0] SUB_LAST  = 3'h7;
    localparam logic [2:0] PHI_HALF  = 3'h4;
    localparam logic [2:0] CIS2_PRE  = 3'h6;
    localparam int         PWM_W     = 12;    // Period 4096 counts

    typedef struct packed {
        logic       tr1;
        logic       tr2;
        logic       rsg;
        logic       auxa;
        logic       auxb;
        logic       clamp;
        logic       sref;
        logic       ssig;
        logic       phi1;
        logic       conv;
    } sslt_sens_t;
endpackage : sslt_pkg

// *** src/sslt_pwm.sv ***
/*
 Fixed period lamp dimming modulator.
 Assumes duty comes from a register on the same clock.
*/
`timescale 1ns/1ps
module sslt_pwm
    import sslt_pkg::*;
#(
    parameter int W = PWM_W
)(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         run,
    input  wire logic [W-1:0] duty,
    output logic              pwm_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         q;
    } sslt_pwm_st_t;

    sslt_pwm_st_t r, s;

    always_comb
    begin
        s = r;
        s.cnt = run ? W'(r.cnt + 1'b1) : '0;
        s.q   = run && (r.cnt < duty);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            r <= '0;
        else
            r <= s;
    end

    assign pwm_out = r.q;
endmodule : sslt_pwm

// *** verif/sslt_props.sv ***
/*
 Concurrent checks on the ports of the sensor and lamp timing block.
 Assumes a bind onto sslt_timing; control and guard register writes are shadowed here.
*/
`timescale 1ns/1ps
module sslt_props
    import sslt_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RST_B,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic              LAMP_B,
    input wire logic              PHI1,
    input wire logic              FIRST_TRANSFER_PULSE,
    input wire logic              RESET_GATE_PULSE,
    input wire logic              AUX_PULSE_A,
    input wire logic              AUX_PULSE_B,
    input wire logic              SAMPLE_SIG,
    input wire logic              USE_INT_REF,
    input wire logic              ADC_CONV,
    input wire logic [1:0]        MUX_SEL,
    input wire logic              LINE_START
);
    // ********************************
    // Shadow of the settings
    // ********************************
    logic [15:0] ctrl_r;
    logic        guard0_r;
    logic [7:0]  age_r;
    logic        halt;
    logic        settled;
    logic        notline;

    // A change mid-line may bend that one line, so checks wait until settings sit still
    assign halt    = ctrl_r[CTL_SRST] | ctrl_r[CTL_STBY];
    assign settled = (age_r == 8'hFF) && !halt;
    assign notline = ctrl_r[CTL_AFE+:2] != AFE_LINE;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl_r   <= CTRL_RST;
            guard0_r <= 1'b1;
            age_r    <= 8'h00;
        end
        else if (WR)
        begin
            age_r <= 8'h00;
            if (ADDR == REG_CTRL)
                ctrl_r <= WDATA;
            if (ADDR == REG_GUARD)
                guard0_r <= (WDATA == 16'h0000);
        end
        else if (age_r != 8'hFF)
            age_r <= age_r + 8'h01;
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // ********************************
    // Properties
    // ********************************
    property p_rd_quiet;
        !$past(RD) |-> RDATA == 16'h0000;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its slot");

    property p_halt_quiet;
        halt && $past(halt, 3) |-> !(PHI1 || FIRST_TRANSFER_PULSE || RESET_GATE_PULSE || ADC_CONV || SAMPLE_SIG);
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("sensor clocking while halted");

    property p_cds_off;
        settled |-> USE_INT_REF == !ctrl_r[CTL_CDS];
    endproperty
    a_cds_off: assert property (p_cds_off) else $error("internal reference select wrong");

    property p_sig_once;
        settled && SAMPLE_SIG |=> !SAMPLE_SIG [*7];
    endproperty
    a_sig_once: assert property (p_sig_once) else $error("signal sample twice in a pixel");

    property p_conv_rate;
        settled && ADC_CONV |=> !ADC_CONV [*7];
    endproperty
    a_conv_rate: assert property (p_conv_rate) else $error("conversion faster than one per pixel");

    property p_mux_line;
        settled && !notline && $changed(MUX_SEL) |-> LINE_START || $past(LINE_START) || $past(LINE_START, 2);
    endproperty
    a_mux_line: assert property (p_mux_line) else $error("channel changed inside a line");

    property p_rsg_end;
        settled && notline && LINE_START |-> !$past(RESET_GATE_PULSE, 3) && !$past(AUX_PULSE_A, 3)
            && !$past(AUX_PULSE_B, 3);
    endproperty
    a_rsg_end: assert property (p_rsg_end) else $error("pixel pulse in the line end pixel");

    property p_tr_phi;
        settled && notline && guard0_r && ctrl_r[CTL_TRMODE+:2] == TRM_NORM && FIRST_TRANSFER_PULSE |-> PHI1;
    endproperty
    a_tr_phi: assert property (p_tr_phi) else $error("transfer pulse outside phase one");

    property p_line_gap;
        LINE_START |=> !LINE_START [*7];
    endproperty
    a_line_gap: assert property (p_line_gap) else $error("line shorter than one pixel");

    c_line: cover property (LINE_START);
    c_tr: cover property (settled && FIRST_TRANSFER_PULSE && PHI1);
    c_mux: cover property (settled && !notline && $changed(MUX_SEL));
    c_lamp: cover property ($rose(LAMP_B));
endmodule : sslt_props

// *** verif/sslt_sensor_model.sv ***
/*
 Passive model of the image sensor and its three lamps.
 Assumes lamp levels and the line start pulse come straight from the timing block.
*/
`timescale 1ns/1ps
module sslt_sensor_model
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] lamp,
    input  wire logic       line_start,
    output int              line_len,
    output int              hi [3],
    output int              lines
);
    // ********************************
    // Light integrated per line
    // ********************************
    int acc [3];
    int len;

    // Drives nothing back, like a real array; an unknown lamp level counts as dark
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lines    <= 0;
            len      <= 0;
            line_len <= 0;
            acc      <= '{0, 0, 0};
            hi       <= '{0, 0, 0};
        end
        else if (line_start === 1'b1)
        begin
            lines    <= lines + 1;
            line_len <= len;
            hi       <= acc;
            len      <= 1;
            foreach (acc[i])
                acc[i] <= int'(lamp[i] === 1'b1);
        end
        else
        begin
            len <= len + 1;
            foreach (acc[i])
                acc[i] <= acc[i] + int'(lamp[i] === 1'b1);
        end
    end
endmodule : sslt_sensor_model

// *** verif/test_scan_sensor_lamp_timing.sv ***
/*
 Self-checking bench for the sensor and lamp timing block.
 Assumes the package, the design and the sensor model are compiled first.
*/
`timescale 1ns/1ps
module test_scan_sensor_lamp_timing
    import sslt_pkg::*;
;
    logic              CLK, RST_B, WR, RD;
    logic [ADDR_W-1:0] ADDR;
    logic [DATA_W-1:0] WDATA, RDATA;
    logic              LAMP_R, LAMP_G, LAMP_B, PHI1, FIRST_TRANSFER_PULSE, SECOND_TRANSFER_PULSE;
    logic              RESET_GATE_PULSE, AUX_PULSE_A, AUX_PULSE_B, CLAMP, SAMPLE_REF, SAMPLE_SIG;
    logic              USE_INT_REF, ADC_CONV, SCAN_ACTIVE, LINE_START;
    logic [1:0]        MUX_SEL;
    logic [1:0]        mq [$];
    int                err_total, checks, line_len, lines, le, d, n;
    int                hi [3];
    int                on [3];
    int                off [3];
    logic [4:0]        ra [6] = '{REG_CTRL, REG_LINEEND, REG_TRW, REG_RSG, REG_SAMP, REG_OBEND};
    logic [15:0]       rv [6] = '{CTRL_RST, LINEEND_RST, TRW_RST, RSG_RST, SAMP_RST, OBEND_RST};

    sslt_timing uut (.CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .LAMP_R, .LAMP_G, .LAMP_B, .PHI1,
        .FIRST_TRANSFER_PULSE, .SECOND_TRANSFER_PULSE, .RESET_GATE_PULSE, .AUX_PULSE_A, .AUX_PULSE_B, .CLAMP,
        .SAMPLE_REF, .SAMPLE_SIG, .USE_INT_REF, .ADC_CONV, .MUX_SEL, .SCAN_ACTIVE, .LINE_START);
    sslt_sensor_model sen (.clk(CLK), .rst_b(RST_B), .lamp({LAMP_B, LAMP_G, LAMP_R}), .line_start(LINE_START),
        .line_len(line_len), .hi(hi), .lines(lines));

    // ********************************
    // Checking and bus tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    task automatic results;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Strobe dropped then one idle edge, so no signal is assigned twice in a step
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask : wr

    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
        @(posedge CLK);
    endtask : rc

    task automatic wl(input int k);
        int t;
        t = lines + k;
        while (lines < t)
            @(posedge CLK);
    endtask : wl

    task automatic steps;
        for (int i = 1; i < mq.size(); i++)
            chk(mq[i], (int'(mq[i-1]) + 1) % 3);
    endtask : steps

    // Expected exposure of one lamp over a steady line
    function automatic int exp_hi(input int a, input int b, input int e);
        if (a > e || a == b)
            return 0;
        if (b > e)
            return (e + 1) * 8;
        return (b > a) ? (b - a) * 8 : (e + 1 - a + b) * 8;
    endfunction : exp_hi

    function automatic logic [15:0] cw(input logic [1:0] lm, input logic [1:0] af, input logic [15:0] x);
        logic [15:0] v;
        v = x;
        v[CTL_LMODE+:2] = lm;
        v[CTL_AFE+:2] = af;
        return v;
    endfunction : cw

    // ********************************
    // Stimulus
    // ********************************
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    initial
    begin
        #3200000;
        err_total++;
        results();
    end

    initial
    begin
        {ADDR, WDATA, WR, RD, RST_B} = '0;
        err_total = 0;
        checks = 0;
        d = $urandom(32'hF5B1F51F);
        repeat (16) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        foreach (ra[i])
            rc(ra[i], rv[i]);
        rc(5'h1F, 16'h0000);
        rc(REG_STATUS, 16'h0000);
        repeat (300) @(posedge CLK);
        chk(lines, 0);
        le = 8 + $urandom % 20;
        wr(REG_LINEEND, 16'(le));
        rc(REG_LINEEND, 16'(le));
        foreach (on[c])
        begin
            on[c] = 1 + $urandom % 4;
            off[c] = on[c] + 1 + $urandom % 4;
        end
        on[1] = le + 1 + $urandom % 8;
        off[2] = le + 1 + $urandom % 8;
        foreach (on[c])
        begin
            wr(REG_LAMP0 + 5'(2 * c), 16'(on[c]));
            wr(REG_LAMP0 + 5'(2 * c + 1), 16'(off[c]));
        end
        wr(REG_CTRL, cw(LMODE_3, AFE_PIX, 16'h0010));
        wl(3);
        chk(line_len, (le + 1) * 8);
        foreach (hi[c])
            chk(hi[c], exp_hi(on[c], off[c], le));
        wr(REG_CTRL, cw(LMODE_1, AFE_PIX, 16'h0010));
        for (int k = 0; k < 3; k++)
        begin
            d = (k == 0) ? 0 : (k == 1) ? $urandom % 4096 : 4095;
            wr(REG_PWM, 16'(d));
            repeat (4200) @(posedge CLK);
            n = 0;
            repeat (4096)
            begin
                @(posedge CLK);
                n += int'(LAMP_G === 1'b1);
            end
            chk(n, d);
        end
        chk(hi[0], exp_hi(on[0], off[0], le));
        chk(hi[2], exp_hi(on[2], off[2], le));
        mq.delete();
        wl(1);
        while (mq.size() < 6)
        begin
            @(posedge CLK);
            if (ADC_CONV === 1'b1)
                mq.push_back(MUX_SEL);
        end
        steps();
        wr(REG_CTRL, cw(LMODE_1, AFE_LINE, 16'h0010));
        wl(2);
        mq.delete();
        repeat (4)
        begin
            wl(1);
            repeat (20) @(posedge CLK);
            mq.push_back(MUX_SEL);
        end
        steps();
        wr(REG_CTRL, cw(LMODE_1, AFE_GRAY, 16'h1010));
        repeat (3)
        begin
            wl(1);
            chk(SECOND_TRANSFER_PULSE, 1'b1);
            repeat (20) @(posedge CLK);
            chk(SECOND_TRANSFER_PULSE, 1'b0);
            chk(CLAMP, 1'b1);
            chk(MUX_SEL, 2'h2);
        end
        wr(REG_SAMP, 16'h0051);
        wr(REG_CTRL, cw(LMODE_1, AFE_PIX, 16'h0000));
        wl(2);
        repeat (20) @(posedge CLK);
        chk(USE_INT_REF, 1'b1);
        chk(SAMPLE_REF, 1'b0);
        @(negedge PHI1);
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (SAMPLE_SIG !== 1'b1 && n < 16);
        chk(n, 5 - 4 + 1);
        foreach (on[c])
        begin
            wr(REG_LAMP0 + 5'(2 * c), 16'h0001);
            wr(REG_LAMP0 + 5'(2 * c + 1), 16'h0003);
        end
        wr(REG_CTRL, cw(LMODE_2, AFE_LINE, 16'h0010));
        wl(4);
        wr(REG_CTRL, cw(LMODE_2, AFE_LINE, 16'h0410));
        chk(SCAN_ACTIVE, 1'b0);
        while (SCAN_ACTIVE !== 1'b1)
            @(posedge CLK);
        @(posedge CLK);
        for (int c = 0; c < 3; c++)
        begin
            wl(1);
            foreach (hi[k])
                chk(hi[k], (k == c) ? 16 : 0);
        end
        foreach (ra[i])
        begin
            if (i < 2)
            begin
                wr(REG_CTRL, 16'h0011 | (16'h0001 << (i ? CTL_SRST : CTL_STBY)));
                repeat (5) @(posedge CLK);
                n = lines;
                repeat (400) @(posedge CLK);
                chk(lines, n);
                chk(PHI1, 1'b0);
                wr(REG_CTRL, cw(LMODE_1, AFE_PIX, 16'h0010));
                wl(1);
            end
        end
        RST_B <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        foreach (ra[i])
            rc(ra[i], rv[i]);
        results();
    end
endmodule : test_scan_sensor_lamp_timing

bind sslt_timing sslt_props chk (.CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .LAMP_B, .PHI1,
    .FIRST_TRANSFER_PULSE, .RESET_GATE_PULSE, .AUX_PULSE_A, .AUX_PULSE_B, .SAMPLE_SIG, .USE_INT_REF,
    .ADC_CONV, .MUX_SEL, .LINE_START);
